/* File: src/nand_program_erase_sequencer.v */
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "nand_host_map.vh"
module nand_program_erase_sequencer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg ce_n,
    output reg cle,
    output reg ale,
    output reg we_n,
    output reg re_n,
    output reg wp_n,
    output reg [7:0] io_out,
    output reg io_oe_n,
    input wire [7:0] io_in,
    input wire ready_busy_n
);
    localparam [3:0] S_IDLE = 4'd0;
    localparam [3:0] S_GO = 4'd1;
    localparam [3:0] S_WLO = 4'd2;
    localparam [3:0] S_WHI = 4'd3;
    localparam [3:0] S_DATA = 4'd4;
    localparam [3:0] S_TWB = 4'd5;
    localparam [3:0] S_BUSY = 4'd6;
    localparam [3:0] S_RLO = 4'd7;
    localparam [3:0] S_RHI = 4'd8;
    localparam [31:0] WP_W = `T_WP_CYC;
    localparam [31:0] WH_W = `T_WH_CYC;
    localparam [31:0] RLO_W = `T_RLO_CYC;
    localparam [31:0] RH_W = `T_RH_CYC;
    localparam [31:0] WB_W = `T_WB_CYC;
    localparam [7:0] WP_CYC = WP_W[7:0];
    localparam [7:0] WH_CYC = WH_W[7:0];
    localparam [7:0] RLO_CYC = RLO_W[7:0];
    localparam [7:0] RH_CYC = RH_W[7:0];
    localparam [7:0] WB_CYC = WB_W[7:0];

    reg [3:0] state_r;
    reg [3:0] step_r;
    reg [2:0] op_r;
    reg cache_r;
    reg [7:0] cnt_r;
    reg [11:0] left_r;
    reg [15:0] col_r;
    reg [23:0] row_r;
    reg [11:0] len_r;
    reg [1:0] cfg_r;
    reg [7:0] stat_byte_r;
    reg refused_r;
    reg order_err_r;
    reg cache_active_r;
    reg last_valid_r;
    reg [17:0] last_blk_r;
    reg [5:0] last_page_r;
    reg rb_s1_r;
    reg rb_s2_r;
    reg rb_s3_r;
    reg rb_ok_r;
    reg [7:0] io_s1_r;
    reg [7:0] io_s2_r;
    reg [7:0] io_s3_r;
    reg [3:0] nstep;
    reg [7:0] cmd_byte;
    reg [31:0] rd_val;
    reg can_ans;
    reg bad_addr;

    wire acc = psel && penable && !pready;
    wire done = psel && penable && pready;
    wire engine_free = (state_r == S_IDLE) || (state_r == S_DATA);
    wire order_bad = last_valid_r && (pwdata[2:0] != `OP_ERASE) &&
        (row_r[23:6] == last_blk_r) && (row_r[5:0] <= last_page_r);

    // The pin is sampled thrice so a change counts only when the last two stages agree.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
            rb_s3_r <= 1'b0;
            rb_ok_r <= 1'b0;
            io_s1_r <= 8'h00;
            io_s2_r <= 8'h00;
            io_s3_r <= 8'h00;
        end else begin
            rb_s1_r <= ready_busy_n;
            rb_s2_r <= rb_s1_r;
            rb_s3_r <= rb_s2_r;
            if (rb_s2_r == rb_s3_r) begin
                rb_ok_r <= rb_s3_r;
            end
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
            io_s3_r <= io_s2_r;
        end
    end

    // Step order: 0 cmd, 1-2 column, 3-5 row, 6 data, 7 confirm, 8 read.
    always @* begin
        nstep = step_r + 4'd1;
        case (step_r)
            4'd0: begin
                if (op_r == `OP_ERASE) begin
                    nstep = 4'd3;
                end else if (op_r == `OP_STAT) begin
                    nstep = cfg_r[0] ? 4'd3 : 4'd8;
                end else if (op_r == `OP_RESET) begin
                    nstep = 4'd9;
                end
            end
            4'd2: begin
                if (op_r == `OP_RAND) begin
                    nstep = 4'd6;
                end
            end
            4'd5: begin
                if (op_r == `OP_ERASE) begin
                    nstep = 4'd7;
                end else if (op_r == `OP_STAT) begin
                    nstep = 4'd8;
                end
            end
            4'd7: nstep = 4'd9;
            default: nstep = step_r + 4'd1;
        endcase
    end

    always @* begin
        cmd_byte = `CMD_PROG;
        case (step_r)
            4'd0: begin
                case (op_r)
                    // Erase opener
                    `OP_ERASE: cmd_byte = `CMD_ERASE;
                    `OP_STAT: cmd_byte = cfg_r[0] ? `CMD_STATE : `CMD_STAT;
                    `OP_RAND: cmd_byte = `CMD_RAND;
                    `OP_RESET: cmd_byte = `CMD_RESET;
                    default: cmd_byte = `CMD_PROG;
                endcase
            end
            4'd1: cmd_byte = col_r[7:0];
            4'd2: cmd_byte = col_r[15:8];
            4'd3: cmd_byte = row_r[7:0];
            4'd4: cmd_byte = row_r[15:8];
            4'd5: cmd_byte = row_r[23:16];
            4'd7: begin
                if (op_r == `OP_ERASE) begin
                    cmd_byte = `CMD_ECONF;
                end else begin
                    cmd_byte = cache_r ? `CMD_CCONF : `CMD_CONF;
                end
            end
            default: cmd_byte = `CMD_PROG;
        endcase
    end

    always @* begin
        can_ans = 1'b1;
        bad_addr = 1'b0;
        rd_val = 32'h0000_0000;
        case (paddr)
            `REG_CTRL: begin
                rd_val = {29'h0, op_r};
                can_ans = !pwrite || engine_free;
            end
            `REG_COL: rd_val = {16'h0, col_r};
            `REG_ROW: rd_val = {8'h0, row_r};
            `REG_LEN: rd_val = {20'h0, len_r};
            // Data writes stall until the engine takes the byte.
            `REG_DATA: can_ans = !pwrite || (state_r == S_DATA);
            `REG_STAT: rd_val = {12'h0, rb_ok_r, stat_byte_r[`SB_ARRAY_READY],
                stat_byte_r[`SB_PREV_CACHE_FAIL_FLAG], stat_byte_r[`SB_FAIL],
                stat_byte_r, 2'h0, order_err_r, refused_r,
                cache_active_r, rb_ok_r, state_r == S_DATA,
                !engine_free};
            `REG_CFG: rd_val = {30'h0, cfg_r};
            default: bad_addr = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            state_r <= S_IDLE;
            step_r <= 4'd0;
            op_r <= `OP_PROG;
            cache_r <= 1'b0;
            cnt_r <= 8'h00;
            left_r <= 12'h000;
            col_r <= 16'h0000;
            row_r <= 24'h00_0000;
            len_r <= 12'h000;
            cfg_r <= `CFG_RESET;
            stat_byte_r <= 8'h00;
            refused_r <= 1'b0;
            order_err_r <= 1'b0;
            cache_active_r <= 1'b0;
            last_valid_r <= 1'b0;
            last_blk_r <= 18'h0_0000;
            last_page_r <= 6'h00;
            ce_n <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            we_n <= 1'b1;
            re_n <= 1'b1;
            wp_n <= 1'b0;
            io_out <= 8'h00;
            io_oe_n <= 1'b1;
        end else begin
            wp_n <= cfg_r[1];
            pready <= 1'b0;
            if (acc && can_ans) begin
                pready <= 1'b1;
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= bad_addr;
            end
            if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
            case (state_r)
                S_GO: begin
                    if (step_r == 4'd6) begin
                        if (left_r == 12'h000) begin
                            step_r <= 4'd7;
                        end else begin
                            state_r <= S_DATA;
                        end
                    end else if (step_r == 4'd8) begin
                        io_oe_n <= 1'b1;
                        re_n <= 1'b0;
                        cnt_r <= RLO_CYC;
                        state_r <= S_RLO;
                    end else if (step_r == 4'd9) begin
                        cnt_r <= WB_CYC;
                        state_r <= S_TWB;
                    end else begin
                        io_out <= cmd_byte;
                        io_oe_n <= 1'b0;
                        cle <= (step_r == 4'd0) || (step_r == 4'd7);
                        ale <= (step_r != 4'd0) && (step_r != 4'd7);
                        we_n <= 1'b0;
                        cnt_r <= WP_CYC;
                        state_r <= S_WLO;
                        if (step_r == 4'd7 && op_r != `OP_ERASE) begin
                            cache_active_r <= cache_r;
                        end
                    end
                end
                S_WLO: begin
                    if (cnt_r <= 8'h01) begin
                        we_n <= 1'b1;
                        cnt_r <= WH_CYC;
                        state_r <= S_WHI;
                    end
                end
                S_WHI: begin
                    if (cnt_r <= 8'h01) begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                        if (step_r == 4'd6) begin
                            state_r <= (left_r == 12'h000) ? S_GO : S_DATA;
                            if (left_r == 12'h000) begin
                                step_r <= 4'd7;
                            end
                        end else begin
                            step_r <= nstep;
                            state_r <= S_GO;
                        end
                    end
                end
                S_TWB: begin
                    if (cnt_r <= 8'h01) begin
                        state_r <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    if (rb_ok_r) begin
                        if (op_r == `OP_RESET) begin
                            cache_active_r <= 1'b0;
                            ce_n <= 1'b1;
                            io_oe_n <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            op_r <= `OP_STAT;
                            step_r <= 4'd0;
                            state_r <= S_GO;
                        end
                    end
                end
                S_RLO: begin
                    if (cnt_r <= 8'h01 && io_s2_r == io_s3_r) begin
                        stat_byte_r <= io_s3_r;
                        if (io_s3_r[`SB_ARRAY_READY]) begin
                            cache_active_r <= 1'b0;
                        end
                        re_n <= 1'b1;
                        cnt_r <= RH_CYC;
                        state_r <= S_RHI;
                    end
                end
                S_RHI: begin
                    if (cnt_r <= 8'h01) begin
                        ce_n <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                end
            endcase
            if (done && pwrite) begin
                case (paddr)
                    `REG_COL: col_r <= pwdata[15:0];
                    `REG_ROW: row_r <= pwdata[23:0];
                    `REG_LEN: len_r <= pwdata[11:0];
                    `REG_CFG: cfg_r <= pwdata[1:0];
                    `REG_DATA: begin
                        io_out <= pwdata[7:0];
                        io_oe_n <= 1'b0;
                        we_n <= 1'b0;
                        cnt_r <= WP_CYC;
                        left_r <= left_r - 12'h001;
                        state_r <= S_WLO;
                    end
                    `REG_CTRL: begin
                        refused_r <= 1'b0;
                        order_err_r <= 1'b0;
                        if (state_r == S_DATA) begin
                            if (pwdata[2:0] == `OP_RAND ||
                                pwdata[2:0] == `OP_RESET) begin
                                op_r <= pwdata[2:0];
                                step_r <= 4'd0;
                                state_r <= S_GO;
                            end else begin
                                refused_r <= 1'b1;
                            end
                        end else if ((!rb_ok_r &&
                            pwdata[2:0] != `OP_STAT &&
                            pwdata[2:0] != `OP_RESET) ||
                            pwdata[2:0] == `OP_RAND ||
                            pwdata[2:0] > `OP_RESET) begin
                            refused_r <= 1'b1;
                        end else if (pwdata[2:0] == `OP_ERASE &&
                            cache_active_r) begin
                            refused_r <= 1'b1;
                        end else if (pwdata[2:0] <= `OP_CACHE && order_bad) begin
                            refused_r <= 1'b1;
                            order_err_r <= 1'b1;
                        end else begin
                            op_r <= pwdata[2:0];
                            cache_r <= pwdata[2:0] == `OP_CACHE;
                            left_r <= len_r;
                            step_r <= 4'd0;
                            ce_n <= 1'b0;
                            state_r <= S_GO;
                            if (pwdata[2:0] <= `OP_CACHE) begin
                                last_valid_r <= 1'b1;
                                last_blk_r <= row_r[23:6];
                                last_page_r <= row_r[5:0];
                            end else if (pwdata[2:0] == `OP_ERASE &&
                                row_r[23:6] == last_blk_r) begin
                                last_valid_r <= 1'b0;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // nand_program_erase_sequencer

/* File: src/nand_host_map.vh */
`ifndef NAND_HOST_MAP_VH
`define NAND_HOST_MAP_VH

`define REG_CTRL 8'h00
`define REG_COL 8'h04
`define REG_ROW 8'h08
`define REG_LEN 8'h0c
`define REG_DATA 8'h10
`define REG_STAT 8'h14
`define REG_CFG 8'h18
`define CFG_RESET 2'h0

`define OP_PROG 3'h0
`define OP_CACHE 3'h1
`define OP_ERASE 3'h2
`define OP_STAT 3'h3
`define OP_RAND 3'h4
`define OP_RESET 3'h5

`define CMD_PROG 8'h80
`define CMD_CONF 8'h10
`define CMD_CCONF 8'h15
`define CMD_ERASE 8'h60
`define CMD_ECONF 8'hd0
`define CMD_STAT 8'h70
`define CMD_STATE 8'h78
`define CMD_RAND 8'h85
`define CMD_RESET 8'hff

`define SB_FAIL 0
`define SB_PREV_CACHE_FAIL_FLAG 1
`define SB_ARRAY_READY 5
`define SB_RDY 6
`define LAST_PAGE 6'h3f

`define CLK_NS 5
`define T_WP_NS 10
`define T_WH_NS 10
`define T_REA_NS 20
`define T_RH_NS 10
`define T_WB_NS 100
`define SYNC_EXTRA 3
`define T_WP_CYC ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WH_CYC ((`T_WH_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RLO_CYC ((`T_REA_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_EXTRA)
`define T_RH_CYC ((`T_RH_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WB_CYC ((`T_WB_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: test/nand_seq_monitor.sv */
`timescale 1ns/1ps
module nand_seq_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire ce_n,
    input wire cle,
    input wire ale,
    input wire we_n,
    input wire re_n,
    input wire [7:0] io_out,
    input wire io_oe_n,
    input wire ready_busy_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence we_pulse;
        !we_n [*2] ##1 we_n [*2];
    endsequence
    sequence byte_held;
        ($stable(io_out) && $stable(cle) && $stable(ale)) [*3];
    endsequence
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_unmapped: assert property (pready |->
        pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0))
        else $error("pslverr does not match the address map");
    a_we_shape: assert property ($fell(we_n) |-> we_pulse)
        else $error("write strobe not two low then two high");
    a_byte_held: assert property ($fell(we_n) |=> byte_held)
        else $error("bus byte changed inside its strobe");
    a_strobe_ce: assert property (!we_n || !re_n |-> !ce_n)
        else $error("strobe while chip not enabled");
    a_write_drives: assert property (!we_n |-> !io_oe_n)
        else $error("write strobe while bus not driven");
    a_read_released: assert property (!re_n |-> io_oe_n && we_n)
        else $error("host drives bus during a read");
    a_re_window: assert property ($fell(re_n) |-> !re_n [*7] ##1 re_n)
        else $error("read strobe not seven cycles low");
    a_busy_cmds: assert property ($fell(we_n) && cle && !ready_busy_n
        |-> io_out inside {8'h70, 8'h78, 8'hff})
        else $error("command other than status or reset while busy");
    a_latch_excl: assert property (!(cle && ale))
        else $error("command and address latch both high");
endmodule // nand_seq_monitor

bind nand_program_erase_sequencer nand_seq_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .io_out(io_out),
    .io_oe_n(io_oe_n), .ready_busy_n(ready_busy_n));

/* File: test/nand_die_model.sv */
`timescale 1ns/1ps
module nand_die_model #(
    parameter int program_time = 60,
    parameter int cache_busy_time = 20,
    parameter int block_erase_time = 80,
    parameter int ecc_program_time = 90
) (
    input wire logic clk,
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wp_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe_n,
    input wire logic fail_en,
    input wire logic ecc_en,
    output logic [7:0] io_in,
    output logic ready_busy_n
);
    logic [7:0] cache [0:15];
    logic [7:0] last_cmd = 8'h00, conf_cmd = 8'h00, last_io = 8'h00;
    logic [23:0] row = 24'h0;
    logic we_q = 1'b1, fail = 1'b0, prev_cache_fail_flag = 1'b0, st_mode = 1'b0;
    int n_addr = 0, ptr = 0, rdy_cnt = 0, array_ready_cnt = 0;
    int t_prog;
    // internal ECC stretches the array program time.
    assign t_prog = ecc_en ? ecc_program_time : program_time;
    wire latch = we_n && !we_q && !ce_n;
    wire col_cmd = last_cmd == 8'h80 || last_cmd == 8'h85;
    // status byte with both fail flags.
    wire [7:0] stat = {wp_n, rdy_cnt == 0, array_ready_cnt == 0, 3'h0, prev_cache_fail_flag, fail};
    assign ready_busy_n = rdy_cnt == 0;
    // Outside a status read, a released bus shows the inverse of its last value, never a hold.
    assign io_in = !io_oe_n ? io_out :
        (!ce_n && !re_n && st_mode) ? stat : ~last_io;
    always @(posedge clk) begin
        last_io <= io_in;
        we_q <= we_n;
        if (rdy_cnt > 0) begin
            rdy_cnt <= rdy_cnt - 1;
        end
        if (array_ready_cnt > 0) begin
            array_ready_cnt <= array_ready_cnt - 1;
        end
        // commands latched on the strobe rise.
        if (latch && cle) begin
            last_cmd <= io_out;
            n_addr <= 0;
            st_mode <= io_out == 8'h70 || io_out == 8'h78;
            case (io_out)
                8'h80: for (int k = 0; k < 16; k++) cache[k] <= 8'hff;
                8'h10, 8'h15: begin
                    conf_cmd <= io_out;
                    fail <= fail_en;
                    prev_cache_fail_flag <= io_out == 8'h15 ? fail : 1'b0;
                    rdy_cnt <= array_ready_cnt + (io_out == 8'h15 ?
                        cache_busy_time : t_prog);
                    array_ready_cnt <= array_ready_cnt + t_prog +
                        (io_out == 8'h15 ? cache_busy_time : 0);
                end
                8'hd0: begin
                    conf_cmd <= io_out;
                    fail <= fail_en;
                    prev_cache_fail_flag <= 1'b0;
                    rdy_cnt <= block_erase_time;
                    array_ready_cnt <= block_erase_time;
                end
                8'hff: begin
                    rdy_cnt <= 4;
                    array_ready_cnt <= 4;
                end
                default: ;
            endcase
        end else if (latch && ale) begin
            n_addr <= n_addr + 1;
            // column then row bytes, low byte first.
            if (col_cmd && n_addr < 2) begin
                if (n_addr == 0) begin
                    ptr <= io_out;
                end
            end else begin
                row[8 * (n_addr - (col_cmd ? 2 : 0)) +: 8] <= io_out;
            end
        end else if (latch) begin
            cache[ptr[3:0]] <= io_out;
            ptr <= ptr + 1;
        end
    end
endmodule // nand_die_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
`include "nand_host_map.vh"
module testbench;
    typedef struct packed {
        logic [2:0] op;
        logic [23:0] row;
        logic fail;
        logic [7:0] cmd;
        logic [2:0] st;
    } row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic fail_en = 0, ecc_en = 0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, s;
    wire [31:0] prdata;
    wire pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb_n;
    wire [7:0] io_out, io_in;
    int failures = 0, n_checks = 0;
    row_t rows [0:6];
    always #2.5 pclk = ~pclk;
    nand_program_erase_sequencer dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n),
        .io_in(io_in), .ready_busy_n(rb_n));
    nand_die_model dev_u (.clk(pclk), .ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
        .io_oe_n(io_oe_n), .fail_en(fail_en), .ecc_en(ecc_en), .io_in(io_in),
        .ready_busy_n(rb_n));
    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask
    // The request is held until pready is sampled; a dead slave ends the run.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        s = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        if (n == 4000) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        apb(0, `REG_STAT, 0);
        while (s[0] !== 1'b0 && n < 500) begin
            apb(0, `REG_STAT, 0);
            n++;
        end
        if (n == 500) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic start(input logic [2:0] op, input logic [23:0] r,
        input logic [31:0] len);
        apb(1, `REG_ROW, {8'h0, r});
        apb(1, `REG_LEN, len);
        apb(1, `REG_COL, 32'h2);
        apb(1, `REG_CTRL, {29'h0, op});
        for (int k = 0; k < len; k++) begin
            apb(1, `REG_DATA, 32'ha0 + k);
        end
    endtask
    initial begin
        rows[0] = '{`OP_PROG, 24'h000001, 1'b0, 8'h10, 3'h4};
        rows[1] = '{`OP_PROG, 24'h000002, 1'b1, 8'h10, 3'h5};
        rows[2] = '{`OP_ERASE, 24'h000045, 1'b0, 8'hd0, 3'h4};
        rows[3] = '{`OP_STAT, 24'h000045, 1'b0, 8'h70, 3'h4};
        rows[4] = '{`OP_CACHE, 24'h000003, 1'b1, 8'h15, 3'h1};
        rows[5] = '{`OP_CACHE, 24'h000004, 1'b0, 8'h15, 3'h2};
        rows[6] = '{`OP_CACHE, 24'h000005, 1'b0, 8'h15, 3'h0};
        repeat (20) @(posedge pclk);
        chk({ce_n, we_n, re_n, io_oe_n, wp_n, cle, ale}, 32'h78);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `REG_CFG, 0);
        chk(s, 32'h0);
        apb(0, 8'h1c, 0);
        chk({31'h0, e}, 32'h1);
        foreach (rows[i]) begin
            fail_en <= rows[i].fail;
            start(rows[i].op, rows[i].row, rows[i].op < 2 ? 4 : 0);
            wait_idle();
            chk(s[18:16], rows[i].st);
            chk8(rows[i].op > 2 ? dev_u.last_cmd : dev_u.conf_cmd,
                rows[i].cmd);
            if (rows[i].op < 3) begin
                chk(dev_u.row, rows[i].row);
            end
            for (int k = 0; k < 4 && rows[i].op < 2; k++) begin
                chk8(dev_u.cache[2 + k], 8'ha0 + k);
            end
        end
        start(`OP_ERASE, 24'h000080, 0);
        apb(0, `REG_STAT, 0);
        chk(s[4], 1);
        start(`OP_PROG, 24'h000006, 4);
        wait_idle();
        chk8(dev_u.conf_cmd, 8'h10);
        chk(s[18:16], 3'h4);
        start(`OP_PROG, 24'h000003, 0);
        apb(0, `REG_STAT, 0);
        chk(s[5:4], 2'h3);
        start(`OP_RESET, 24'h0, 0);
        wait_idle();
        chk8(dev_u.last_cmd, 8'hff);
        apb(1, `REG_CFG, 32'h3);
        start(`OP_STAT, 24'h000123, 0);
        wait_idle();
        chk8(dev_u.last_cmd, 8'h78);
        chk(dev_u.row, 24'h000123);
        chk(s[15], 1);
        ecc_en <= 1;
        apb(1, `REG_ROW, 32'h7);
        apb(1, `REG_LEN, 32'h4);
        apb(1, `REG_COL, 32'h2);
        apb(1, `REG_CTRL, {29'h0, `OP_PROG});
        apb(1, `REG_DATA, 32'hb0);
        apb(1, `REG_DATA, 32'hb1);
        apb(1, `REG_COL, 32'h8);
        apb(1, `REG_CTRL, {29'h0, `OP_RAND});
        apb(1, `REG_DATA, 32'hb2);
        apb(1, `REG_DATA, 32'hb3);
        wait_idle();
        chk8(dev_u.cache[3], 8'hb1);
        chk8(dev_u.cache[8], 8'hb2);
        chk8(dev_u.cache[9], 8'hb3);
        chk8(dev_u.cache[4], 8'hff);
        chk(s[18:16], 3'h4);
        tally_and_finish();
    end
endmodule // testbench
